// ---- hw/reset_watchdog_consts.svh ----
// Purpose: constants for the monitor card reset and supervision block
// Assumes: 10 MHz mclk
// Notes: timing counts derive from times in their own units
// How it works
// - Shared reset line driven by either side
// - Master reset low resets cpu and select latch
// - Same reset hits serial and usb parts
// - Port control latch reset after a delay
// - Arm bit then stop watchdog strobes
// - Watchdog expiry after one second drives line
// - Delayed reset clears arm, releases line
// - Supply undervoltage also asserts reset
// - Twelve serial irqs ORed, firmware polls
// - Four latched port control signals
// - Latched inverted eight offboard selects
// - Supply good low while both supplies windowed
// - Decoder output forms expansion select
`ifndef RESET_WATCHDOG_CONSTS_SVH
`define RESET_WATCHDOG_CONSTS_SVH
`define CLK_HZ 10000000
`define WDOG_TIME_MS 1000
`define WDOG_CYCLES ((`WDOG_TIME_MS * (`CLK_HZ / 1000)))
`define DELAY_TIME_US 100
`define DELAY_CYCLES ((`DELAY_TIME_US * `CLK_HZ) / 1000000)
`define SERIAL_IRQ_COUNT 12
`define SELECT_COUNT 8
`define SELECT_RESET 8'h00
`define PORT_RESET 4'h0
`define EXP_REGION 4'hF
`endif

// ---- hw/reset_watchdog_pkg.sv ----
// Purpose: types for the monitor card reset block
// Assumes: constants header included alongside
// Notes: port control travels as one struct
package reset_watchdog_pkg;
   typedef struct packed {
      logic write;        // Write strobe
      logic addr_sel;     // Address select
      logic read_en_n;    // Read enable, low active
      logic direction;    // 1 = into card
   } port_ctrl_type;
   typedef enum logic [2:0] {
      RUN   = 3'b001,
      HOLD  = 3'b010,
      DELAY = 3'b100
   } rst_state_type;
endpackage : reset_watchdog_pkg

// ---- hw/sync2.sv ----
// Purpose: two flip-flop synchroniser for one bit
// Assumes: single clock mclk
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module sync2 #(parameter logic RST_VAL = 1'b0) (
   input wire logic mclk,   // System clock
   input wire logic reset,  // Async reset, high
   input wire logic d,      // Async input
   output logic q           // Synchronised output
);
   logic s1_q;
   // Two stage capture
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s1_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         s1_q <= d;
         q <= s1_q;
      end
   end
endmodule : sync2
`default_nettype wire

// ---- hw/reset_watchdog.sv ----
// Purpose: reset sequencing, watchdog and glue of the monitor card
// Assumes: 10 MHz mclk, async active-high reset
// Notes: watchdog and delay counts are parameters for fast simulation
// Notes: the port latch clears one edge after the delayed reset
`timescale 1ns/1ps
`default_nettype none
`include "reset_watchdog_consts.svh"
module reset_watchdog
   import reset_watchdog_pkg::*;
#(
   parameter int WDOG_CYC = `WDOG_CYCLES,
   parameter int DELAY_CYC = `DELAY_CYCLES
) (
   input wire logic mclk,                 // System clock
   input wire logic reset,                // Async reset, high
   input wire logic shared_reset_in,      // Line level, low = reset
   output logic shared_reset_out,         // Line drive value, always 0
   output logic shared_reset_oe,          // Low = card drives line low
   input wire logic supply_low,           // Supply below threshold pin
   input wire logic wdog_strobe,          // Watchdog strobe pin
   input wire logic arm_set,              // Firmware sets reset arm
   output logic reset_arm_bit,            // Arm bit state
   output logic cpu_reset_n,              // Cpu and select latch reset
   output logic periph_reset,             // Uart and usb reset, high
   output logic delayed_reset_n,          // Port latch reset, delayed
   input wire logic [11:0] serial_irq,    // Twelve uart irq pins
   output logic merged_irq,               // ORed irq
   input wire logic port_load,            // Load port control
   input wire port_ctrl_type port_ctrl_in, // New port control
   output port_ctrl_type port_ctrl,       // Latched port control
   input wire logic sel_load,             // Load select latch
   input wire logic [7:0] sel_in,         // High = select device
   output logic [7:0] offboard_select_n,  // Low active selects
   input wire logic supply5_ok,           // 5V window pin
   input wire logic supply3_ok,           // 3.3V window pin
   output logic supply_good_n,            // Low when both good
   input wire logic [3:0] addr_region,    // Decoder address field
   input wire logic mem_sel,              // Valid memory cycle
   output logic expansion_select          // Low active expansion select
);
   ////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Every pin below is asynchronous to mclk, so no logic reads it
   // before it has passed both flip-flops of its synchroniser.
   logic line_s, low_s, strobe_s, s5_s, s3_s;
   logic [11:0] irq_s;
   // Line resets to its idle high level, so release gives no false reset
   sync2 #(.RST_VAL(1'b1)) u_line (
      .mclk(mclk),
      .reset(reset),
      .d(shared_reset_in),
      .q(line_s)
   );
   // Undervoltage pin, high while the supply is below threshold
   sync2 u_low (
      .mclk(mclk),
      .reset(reset),
      .d(supply_low),
      .q(low_s)
   );
   // Watchdog strobe pin; only its toggles matter
   sync2 u_stb (
      .mclk(mclk),
      .reset(reset),
      .d(wdog_strobe),
      .q(strobe_s)
   );
   // Supply window pins
   sync2 u_s5 (
      .mclk(mclk),
      .reset(reset),
      .d(supply5_ok),
      .q(s5_s)
   );
   sync2 u_s3 (
      .mclk(mclk),
      .reset(reset),
      .d(supply3_ok),
      .q(s3_s)
   );
   // One synchroniser per serial channel interrupt
   genvar gi;
   generate
      for (gi = 0; gi < `SERIAL_IRQ_COUNT; gi++) begin : g_irq
         sync2 u_i (
            .mclk(mclk),
            .reset(reset),
            .d(serial_irq[gi]),
            .q(irq_s[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Watchdog and reset sequencer
   // RUN: normal work. HOLD: cpu and peripherals in reset, port latch not yet.
   // DELAY: port latch cleared too, arm bit and line drive dropped.
   // DELAY is left only once the line reads high and the supply is good.
   rst_state_type st_q, st_d;
   logic [31:0] wd_q, wd_d;
   logic [31:0] dl_q, dl_d;
   logic arm_q, arm_d, strobe_q, strobe_d, drive_q, drive_d;
   logic wd_fire;
   // Counter saturates at expiry, so a stuck strobe cannot wrap it
   // one second expiry
   assign wd_fire = (wd_q >= 32'(WDOG_CYC - 1));
   always_comb begin
      st_d = st_q;
      wd_d = wd_q;
      dl_d = dl_q;
      arm_d = arm_q;
      drive_d = drive_q;
      strobe_d = strobe_s;
      if (strobe_s != strobe_q) wd_d = '0;
      else if (!wd_fire) wd_d = wd_q + 32'd1;
      if (arm_set) arm_d = 1'b1;
      unique case (st_q)
         RUN: begin
            if (!line_s || low_s || wd_fire) begin
               st_d = HOLD;
               dl_d = '0;
               // Unarmed expiry resets the card but leaves the line alone
               // drive line only when armed
               drive_d = arm_q | arm_set;
            end
         end
         HOLD: begin
            // Line drive, if on, stays on through HOLD
            // count out the stagger delay
            if (dl_q >= 32'(DELAY_CYC - 1)) st_d = DELAY;
            else dl_d = dl_q + 32'd1;
         end
         DELAY: begin
            // delayed reset clears arm and line
            arm_d = 1'b0;
            drive_d = 1'b0;
            wd_d = '0;
            if (line_s && !low_s) st_d = RUN;
         end
      endcase
   end
   // Sequencer and watchdog registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q <= RUN;
         wd_q <= '0;
         dl_q <= '0;
         arm_q <= 1'b0;
         strobe_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         st_q <= st_d;
         wd_q <= wd_d;
         dl_q <= dl_d;
         arm_q <= arm_d;
         strobe_q <= strobe_d;
         drive_q <= drive_d;
      end
   end
   // Status and reset outputs straight from state
   assign reset_arm_bit = arm_q;
   // open drain line, driven low only
   assign shared_reset_out = 1'b0;
   assign shared_reset_oe = ~drive_q;
   // Trade-off: triggers pass the pin synchronisers, so reset reaches the
   // cpu three edges after the pin changes, not within the same cycle.
   // cpu reset decoded from registered state
   assign cpu_reset_n = (st_q == RUN);
   assign periph_reset = ~cpu_reset_n;
   // Port latch clears on the edge after this goes low
   assign delayed_reset_n = (st_q != DELAY);

   ////////////////////////////////////////////////////////////////
   // Latches and status
   port_ctrl_type pc_q, pc_d;
   logic [7:0] sel_q, sel_d;
   logic irq_q, irq_d, good_n_q, good_n_d, exp_q, exp_d;
   // Next values of latches and status
   always_comb begin
      pc_d = pc_q;
      sel_d = sel_q;
      if (port_load) pc_d = port_ctrl_in;
      if (st_q == DELAY) pc_d = `PORT_RESET;
      if (sel_load) sel_d = sel_in;
      if (st_q != RUN) sel_d = `SELECT_RESET;
      irq_d = |irq_s;
      // low only when both in window
      good_n_d = ~(s5_s & s3_s);
      exp_d = ~(mem_sel && addr_region == `EXP_REGION);
   end
   // Latch and status registers; selects idle high after reset
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pc_q <= `PORT_RESET;
         sel_q <= `SELECT_RESET;
         irq_q <= 1'b0;
         good_n_q <= 1'b1;
         exp_q <= 1'b1;
      end else begin
         pc_q <= pc_d;
         sel_q <= sel_d;
         irq_q <= irq_d;
         good_n_q <= good_n_d;
         exp_q <= exp_d;
      end
   end
   // Data outputs come straight from flip-flops
   assign port_ctrl = pc_q;
   assign offboard_select_n = ~sel_q;
   assign merged_irq = irq_q;
   assign supply_good_n = good_n_q;
   assign expansion_select = exp_q;
endmodule : reset_watchdog
`default_nettype wire

// ---- tb/lcu_model.sv ----
// Purpose: control unit side of the shared reset line
// Assumes: line has a pull-up, both sides open-drain
// Notes: pulls only when the bench asks for a master reset
`timescale 1ns/1ps
`default_nettype none
module lcu_model (
   input wire logic pull_req,  // Bench asks for master reset
   input wire logic card_oe,   // Card enable, low = card pulls
   output logic line_level,    // Resolved line level
   input wire logic lamp_test, // Bench asks indicator check
   input wire logic card_good_n, // Card supply status, low = good
   output logic good_lamp      // Supply lamp as seen on the panel
);
   assign line_level = !(pull_req || !card_oe);
   assign good_lamp = lamp_test || !card_good_n;
endmodule : lcu_model
`default_nettype wire

// ---- tb/reset_watchdog_monitor.sv ----
// Purpose: port checks of the reset and supervision block
// Assumes: one clock, async high reset
// Notes: windows allow 2ff sync plus one register
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_monitor
   import reset_watchdog_pkg::*;
#(parameter int WDOG_CYC = 50, parameter int DELAY_CYC = 4) (
   input wire logic mclk, // System clock
   input wire logic reset, // Async reset, high
   input wire logic shared_reset_in, // Line level
   input wire logic shared_reset_oe, // Low = card pulls line
   input wire logic supply_low, // Undervoltage pin
   input wire logic reset_arm_bit, // Arm bit
   input wire logic cpu_reset_n, // Cpu reset, low
   input wire logic periph_reset, // Peripheral reset, high
   input wire logic delayed_reset_n, // Port latch reset, low
   input wire logic [11:0] serial_irq, // Uart irq pins
   input wire logic merged_irq, // ORed irq
   input wire logic sel_load, // Select latch load
   input wire logic [7:0] sel_in, // Select latch data
   input wire logic [7:0] offboard_select_n, // Low active selects
   input wire logic [3:0] addr_region, // Decoder field
   input wire logic mem_sel, // Memory cycle
   input wire logic expansion_select // Expansion select, low
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////
   // Sequencer outputs against their causes
   a_periph_inverse: assert property (periph_reset == !cpu_reset_n)
      else $error("periph reset not inverse of cpu reset");
   a_line_resets: assert property ($fell(shared_reset_in) |-> ##[1:4] !cpu_reset_n)
      else $error("line low did not reset cpu");
   a_port_delayed: assert property ($fell(cpu_reset_n) |-> delayed_reset_n[*3])
      else $error("port latch reset not delayed");
   a_drive_armed: assert property (!shared_reset_oe |-> reset_arm_bit && !cpu_reset_n)
      else $error("line driven without arm");
   a_arm_cleared: assert property ($fell(delayed_reset_n) |=> !reset_arm_bit && shared_reset_oe)
      else $error("delayed reset left arm or line");
   a_supply_reset: assert property ($rose(supply_low) |-> ##[1:4] !cpu_reset_n)
      else $error("undervoltage did not reset");
   // Glue logic, latency of sync chain included
   a_irq_merged: assert property ((|serial_irq)[*4] |-> merged_irq)
      else $error("merged irq missing");
   a_select_latch: assert property (sel_load && cpu_reset_n |=>
      !cpu_reset_n || offboard_select_n == ~$past(sel_in))
      else $error("select latch wrong");
   a_exp_decode: assert property (mem_sel && addr_region == 4'hF |=> !expansion_select)
      else $error("expansion select not decoded");
   cover property ($fell(shared_reset_oe));
   cover property ($fell(delayed_reset_n));
   cover property ($rose(merged_irq));
endmodule : reset_watchdog_monitor
bind reset_watchdog reset_watchdog_monitor #(.WDOG_CYC(WDOG_CYC), .DELAY_CYC(DELAY_CYC)) u_mon (.*);
`default_nettype wire

// ---- tb/monitor_board_reset_watchdog_bench.sv ----
// Purpose: self-checking bench of the reset and supervision block
// Assumes: short watchdog and delay counts
// Notes: glue from a table, reset paths by hand
`timescale 1ns/1ps
`default_nettype none
module monitor_board_reset_watchdog_bench;
   import reset_watchdog_pkg::*;
   localparam int WD = 50;
   localparam int DL = 4;
   typedef struct packed {
      logic [11:0] irq;
      logic [7:0] sel;
      port_ctrl_type pc;
      logic [3:0] region;
      logic mem, s5, s3, x_irq, x_good_n, x_exp;
   } row_type;
   logic mclk = 1'h0, reset = 1'h1, shared_reset_in, shared_reset_out, shared_reset_oe;
   logic supply_low = 1'h0, wdog_strobe = 1'h0, arm_set = 1'h0, reset_arm_bit;
   logic cpu_reset_n, periph_reset, delayed_reset_n, merged_irq, port_load = 1'h0;
   logic sel_load = 1'h0, supply5_ok = 1'h1, supply3_ok = 1'h1, supply_good_n;
   logic mem_sel = 1'h0, expansion_select, pull = 1'h0, strobing = 1'h1;
   logic lamp_test = 1'h0, good_lamp;
   logic [11:0] serial_irq = 12'h000;
   logic [7:0] sel_in = 8'h00, offboard_select_n;
   logic [3:0] addr_region = 4'h0;
   port_ctrl_type port_ctrl_in = '0, port_ctrl;
   int failures = 0, checked = 0, n;
   row_type rows [4] = '{{12'h800, 8'h01, 4'hA, 4'hF, 6'h3C}, {12'h000, 8'h80, 4'h5, 4'hF, 6'h13},
      {12'h000, 8'h00, 4'h0, 4'h0, 6'h19}, {12'h001, 8'hFF, 4'hF, 4'hE, 6'h2F}};
   reset_watchdog #(.WDOG_CYC(WD), .DELAY_CYC(DL)) DUT (.*);
   lcu_model u_lcu (.pull_req(pull), .card_oe(shared_reset_oe), .line_level(shared_reset_in),
      .lamp_test(lamp_test), .card_good_n(supply_good_n), .good_lamp(good_lamp));
   ////////////////////////////////////////////////////////////////////////////
   always #50 mclk = !mclk;
   // Firmware strobe every ten cycles while enabled
   always begin
      repeat (10) @(posedge mclk);
      #10;
      if (strobing)
         wdog_strobe = !wdog_strobe;
   end
   // Hang guard, well beyond the roughly 28 us the tests need
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #10;
   endtask : cyc
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, table, then reset paths
   initial begin
      cyc(10);
      chk(16'({shared_reset_oe, cpu_reset_n, periph_reset, delayed_reset_n, reset_arm_bit,
         merged_irq, supply_good_n, expansion_select, offboard_select_n}), 16'hD3FF);
      reset = 1'h0;
      cyc(2);
      foreach (rows[i]) begin
         {serial_irq, sel_in, port_ctrl_in, addr_region} = rows[i][33:6];
         {mem_sel, supply5_ok, supply3_ok} = rows[i][5:3];
         {sel_load, port_load} = 2'h3;
         cyc(1);
         {sel_load, port_load} = 2'h0;
         cyc(4);
         chk(16'({offboard_select_n, port_ctrl}), 16'({~rows[i].sel, rows[i].pc}));
         chk(16'({merged_irq, supply_good_n, expansion_select}), 16'(rows[i][2:0]));
      end
      // Last row left a supply out of window, so only the lamp test lights it
      chk(16'(good_lamp), 16'h0000);
      lamp_test = 1'h1;
      cyc(1);
      chk(16'(good_lamp), 16'h0001);
      lamp_test = 1'h0;
      {serial_irq, mem_sel, supply5_ok, supply3_ok} = 15'h0003;
      pull = 1'h1;
      cyc(4);
      chk(16'({cpu_reset_n, periph_reset, shared_reset_oe, offboard_select_n, port_ctrl}), 16'h3FFF);
      for (n = 0; delayed_reset_n !== 1'h0 && n < 30; n++)
         cyc(1);
      // Port latch clears on the edge after the delayed reset appears
      cyc(1);
      chk(16'({n > 0, n < 30, port_ctrl}), 16'h0030);
      pull = 1'h0;
      for (n = 0; cpu_reset_n !== 1'h1 && n < 30; n++)
         cyc(1);
      chk(16'({cpu_reset_n, shared_reset_oe}), 16'h0003);
      arm_set = 1'h1;
      cyc(1);
      arm_set = 1'h0;
      cyc(150);
      chk(16'({reset_arm_bit, cpu_reset_n, shared_reset_oe}), 16'h0007);
      strobing = 1'h0;
      cyc(12);
      wdog_strobe = !wdog_strobe;
      for (n = 0; shared_reset_oe !== 1'h0 && n < 200; n++)
         cyc(1);
      chk(16'({n >= WD, n <= WD + 6, shared_reset_in, cpu_reset_n, periph_reset, reset_arm_bit,
         shared_reset_out}), 16'h0066);
      for (n = 0; shared_reset_oe !== 1'h1 && n < 30; n++)
         cyc(1);
      chk(16'({reset_arm_bit, delayed_reset_n, shared_reset_oe}), 16'h0001);
      strobing = 1'h1;
      for (n = 0; cpu_reset_n !== 1'h1 && n < 30; n++)
         cyc(1);
      chk(16'({cpu_reset_n, delayed_reset_n}), 16'h0003);
      supply_low = 1'h1;
      cyc(5);
      chk(16'({cpu_reset_n, shared_reset_oe}), 16'h0001);
      supply_low = 1'h0;
      // Arm during HOLD, then a mid-run reset must clear all of it
      arm_set = 1'h1;
      cyc(1);
      arm_set = 1'h0;
      reset = 1'h1;
      cyc(1);
      chk(16'({cpu_reset_n, shared_reset_oe, reset_arm_bit, offboard_select_n}), 16'h06FF);
      reset = 1'h0;
      cyc(3);
      chk(16'({cpu_reset_n, reset_arm_bit, shared_reset_oe}), 16'h0005);
      wrap_up();
   end
endmodule : monitor_board_reset_watchdog_bench
`default_nettype wire
